// ### ims_regs.svh
// Register offsets, field positions, reset values and loop constants
// for the image dump and exposure readout block.
// Assumes an 8-bit register address space and 8-bit register data.
`ifndef IMS_REGS_SVH
`define IMS_REGS_SVH

// ==========================================================
// Register offsets
`define IMS_ADDR_CFG 8'h0a
`define IMS_ADDR_RSVD_B 8'h0b
`define IMS_ADDR_OUT_LO 8'h0c
`define IMS_ADDR_OUT_HI 8'h0d
`define IMS_ADDR_EXP_LO 8'h0e
`define IMS_ADDR_EXP_HI 8'h0f
`define IMS_ADDR_FP_LO 8'h10
`define IMS_ADDR_FP_HI 8'h11

// ==========================================================
// Configuration field positions and values
`define IMS_CFG_SOFT_RESET 7
`define IMS_CFG_LED_SHUTTER 6
`define IMS_CFG_SELF_TEST 5
`define IMS_CFG_RES 4
`define IMS_CFG_DUMP 3
`define IMS_CFG_AWAKE 0
`define IMS_CFG_RESET 8'h00
`define IMS_CFG_STORE_MASK 8'h59

// ==========================================================
// Reset values and data encodings
`define IMS_FP_RESET 16'hd120
`define IMS_EXP_RESET 16'h0064
`define IMS_EXP_MIN 16'h0010
`define IMS_EXP_MARGIN 16'h0b00
`define IMS_OUT_INVALID 8'h80
`define IMS_PIX_FIRST 8'h00
`define IMS_PIX_LAST 8'hff
`define IMS_MAX_PIX_HI 6'h39
`define IMS_MAX_PIX_LO 6'h35
`define IMS_EXP_SHIFT 4
`define IMS_CRC_POLY 16'h1021
`define IMS_CRC_SEED 16'hffff

`endif

// ### ims_pkg.sv
// Types shared by the readout block and its exposure loop.
// Assumes ims_regs.svh is compiled alongside.
package ims_pkg;

  // ==========================================================
  // Register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ims_bus_req_t;

  // ==========================================================
  // Activity of the output bytes
  typedef enum logic [1:0] {
    IMS_IDLE,
    IMS_DUMP,
    IMS_TEST
  } ims_mode_t;

  // ==========================================================
  // Whole state of the readout block
  typedef struct packed {
    ims_mode_t mode;
    logic [7:0] cfg;
    logic [15:0] frame_period;
    logic [7:0] fp_stage;
    logic [15:0] frame_cnt;
    logic frame_end;
    logic [7:0] out_hi;
    logic [7:0] out_lo;
    logic [7:0] pix_sel;
    logic dump_done;
    logic [15:0] crc;
    logic [7:0] exp_lo_shadow;
    logic [7:0] rd_data;
    logic exp_clear;
    logic led_on;
  } ims_state_t;

  // ==========================================================
  // Whole state of the exposure loop
  typedef struct packed {
    logic [15:0] exposure;
  } ims_exp_state_t;

endpackage

// ### ims_exposure.sv
// Automatic exposure loop: one step per frame toward a bright-pixel target.
// Assumes step is a one-cycle pulse at each frame end.
`include "ims_regs.svh"

module ims_exposure (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic step,
  input wire logic [5:0] max_pixel,
  input wire logic [15:0] limit,
  output logic [15:0] exposure_q
);
  import ims_pkg::*;

  ims_exp_state_t st_q;
  ims_exp_state_t st_d;
  logic [15:0] delta;
  logic [16:0] raised;

  // ==========================================================
  // Next exposure value
  always_comb begin
    st_d = st_q;
    delta = st_q.exposure >> `IMS_EXP_SHIFT;
    if (delta == 16'h0000) begin
      delta = 16'h0001; // Keeps tiny values from freezing
    end
    raised = {1'b0, st_q.exposure} + {1'b0, delta};
    if (clear) begin
      st_d.exposure = `IMS_EXP_RESET;
    end else if (step) begin
      if (max_pixel > `IMS_MAX_PIX_HI) begin
        // Too bright: shorten, never below the floor
        if (st_q.exposure - delta < `IMS_EXP_MIN || st_q.exposure < delta) begin
          st_d.exposure = `IMS_EXP_MIN;
        end else begin
          st_d.exposure = st_q.exposure - delta;
        end
      end else if (max_pixel < `IMS_MAX_PIX_LO) begin
        st_d.exposure = raised[15:0];
        if (raised[16] || raised[15:0] > limit) begin
          st_d.exposure = limit;
        end
      end else if (st_q.exposure > limit) begin
        st_d.exposure = limit;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q.exposure <= `IMS_EXP_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign exposure_q = st_q.exposure;

endmodule // ims_exposure

// ### ims_readout.sv
// Readout registers of the motion sensor: data output word carrying
// self-test or pixel dump results, exposure report, frame timer.
// Assumes the pixel array answers pix_sample for pix_sel_q in the
// same cycle, and max_pixel holds the brightest pixel of the last frame.
`include "ims_regs.svh"

module ims_readout #(
  // Test result words; values are arbitrary
  parameter logic [15:0] TEST_PASS_WORD = 16'h5a3c,
  parameter logic [15:0] TEST_FAIL_WORD = 16'hc3a5,
  // Expected signature of the array walk; value is arbitrary
  parameter logic [15:0] TEST_GOLDEN_CRC = 16'h1d0f
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire ims_pkg::ims_bus_req_t bus_req,
  output logic [7:0] rd_data_q,
  input wire logic [5:0] pix_sample,
  input wire logic [5:0] max_pixel,
  output logic [7:0] pix_sel_q,
  output logic frame_end_q,
  output logic led_on_q,
  output logic [15:0] exposure_q
);
  import ims_pkg::*;

  ims_state_t st_q;
  ims_state_t st_d;
  logic [15:0] exposure;
  logic [15:0] period_cycles;
  logic [15:0] exp_limit;
  logic [16:0] frame_next;
  logic dump_req;
  logic test_req;
  logic soft_req;

  // ==========================================================
  // One CRC step over an 8-bit sample, MSB first
  function automatic logic [15:0] crc_step(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data[i]) begin
        c = {c[14:0], 1'b0} ^ `IMS_CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // ==========================================================
  // Power-up and soft reset contents
  function automatic ims_state_t reset_state();
    ims_state_t s;
    s.mode = IMS_IDLE;
    s.cfg = `IMS_CFG_RESET;
    s.frame_period = `IMS_FP_RESET;
    s.fp_stage = 8'(`IMS_FP_RESET); // Lower byte of the default period
    s.frame_cnt = `IMS_FP_RESET;
    s.frame_end = 1'b0;
    s.out_hi = 8'h00;
    s.out_lo = `IMS_OUT_INVALID;
    s.pix_sel = `IMS_PIX_FIRST;
    s.dump_done = 1'b0;
    s.crc = `IMS_CRC_SEED;
    s.exp_lo_shadow = 8'(`IMS_EXP_RESET);
    s.rd_data = 8'h00;
    s.exp_clear = 1'b0;
    s.led_on = 1'b1;
    return s;
  endfunction

  // ==========================================================
  // Exposure ceiling from the frame period
  // The period register holds a negative count, so its negation is
  // the number of clock cycles per frame.
  always_comb begin
    period_cycles = 16'(~st_q.frame_period + 16'h0001);
    if (period_cycles > `IMS_EXP_MARGIN + `IMS_EXP_MIN) begin
      exp_limit = period_cycles - `IMS_EXP_MARGIN;
    end else begin
      exp_limit = `IMS_EXP_MIN; // Absurdly short frames still expose a little
    end
  end

  // ==========================================================
  // Exposure loop, stepped once per frame
  ims_exposure u_exposure (
    .core_clk(core_clk),
    .reset(reset),
    .clear(st_q.exp_clear),
    .step(st_q.frame_end),
    .max_pixel(max_pixel),
    .limit(exp_limit),
    .exposure_q(exposure)
  );

  // ==========================================================
  // Decoded configuration writes
  always_comb begin
    soft_req = 1'b0;
    test_req = 1'b0;
    dump_req = 1'b0;
    if (bus_req.wr && bus_req.addr == `IMS_ADDR_CFG) begin
      soft_req = bus_req.wdata[`IMS_CFG_SOFT_RESET];
      test_req = bus_req.wdata[`IMS_CFG_SELF_TEST];
      // Only a fresh 0 to 1 of the dump bit restarts a dump
      dump_req = bus_req.wdata[`IMS_CFG_DUMP] && !st_q.cfg[`IMS_CFG_DUMP];
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.frame_end = 1'b0;
    st_d.exp_clear = 1'b0;
    st_d.rd_data = 8'h00;

    // Frame timer counts up and reloads on overflow
    frame_next = {1'b0, st_q.frame_cnt} + 17'h0_0001;
    if (frame_next[16]) begin
      st_d.frame_cnt = st_q.frame_period;
      st_d.frame_end = 1'b1;
    end else begin
      st_d.frame_cnt = frame_next[15:0];
    end

    // Register reads; data stand in the following cycle only
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `IMS_ADDR_CFG: st_d.rd_data = st_q.cfg;
        `IMS_ADDR_OUT_LO: st_d.rd_data = st_q.out_lo;
        `IMS_ADDR_OUT_HI: st_d.rd_data = st_q.out_hi;
        `IMS_ADDR_EXP_LO: st_d.rd_data = st_q.exp_lo_shadow;
        `IMS_ADDR_EXP_HI: begin
          // Freeze the low byte so the pair belongs to one frame
          st_d.rd_data = exposure[15:8];
          st_d.exp_lo_shadow = exposure[7:0];
        end
        `IMS_ADDR_FP_LO: st_d.rd_data = st_q.frame_period[7:0];
        `IMS_ADDR_FP_HI: st_d.rd_data = st_q.frame_period[15:8];
        default: st_d.rd_data = 8'h00; // Reserved and unmapped read zero
      endcase
    end

    // Register writes; the data output and exposure bytes ignore writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `IMS_ADDR_CFG: begin
          // Soft reset and self test are commands and read back as zero
          st_d.cfg = bus_req.wdata & `IMS_CFG_STORE_MASK;
        end
        `IMS_ADDR_FP_LO: st_d.fp_stage = bus_req.wdata;
        `IMS_ADDR_FP_HI: begin
          // Period is committed whole when the upper byte lands
          st_d.frame_period = {bus_req.wdata, st_q.fp_stage};
        end
        default: begin
        end
      endcase
    end

    // Output word activity
    unique case (st_q.mode)
      IMS_IDLE: begin
        if (dump_req) begin
          st_d.mode = IMS_DUMP;
        end
      end
      IMS_DUMP: begin
        if (!st_q.cfg[`IMS_CFG_DUMP]) begin
          st_d.mode = IMS_IDLE; // Host cleared the dump bit
        end else if (frame_next[16] && !st_q.dump_done) begin
          // One pixel per frame: address high, sample low
          st_d.out_hi = st_q.pix_sel;
          // Low six bits carry 0..63, MSB low marks valid
          st_d.out_lo = {2'b00, pix_sample};
          if (st_q.pix_sel == `IMS_PIX_LAST) begin
            st_d.dump_done = 1'b1;
          end else begin
            st_d.pix_sel = st_q.pix_sel + 8'h01;
          end
        end
      end
      IMS_TEST: begin
        // Walk every pixel of the array into the signature
        st_d.crc = crc_step(st_q.crc, {2'b00, pix_sample});
        if (st_q.pix_sel == `IMS_PIX_LAST) begin
          st_d.mode = IMS_IDLE;
          if (st_d.crc == TEST_GOLDEN_CRC) begin
            {st_d.out_hi, st_d.out_lo} = TEST_PASS_WORD;
          end else begin
            {st_d.out_hi, st_d.out_lo} = TEST_FAIL_WORD;
          end
          st_d.pix_sel = `IMS_PIX_FIRST;
        end else begin
          st_d.pix_sel = st_q.pix_sel + 8'h01;
        end
      end
      default: st_d.mode = IMS_IDLE;
    endcase

    // A new dump starts invalid at the first pixel
    if (dump_req && !test_req && !soft_req) begin
      st_d.mode = IMS_DUMP;
      st_d.pix_sel = `IMS_PIX_FIRST;
      st_d.dump_done = 1'b0;
      st_d.out_hi = `IMS_PIX_FIRST;
      st_d.out_lo = `IMS_OUT_INVALID;
    end

    // Self test: the test rewrites configuration to defaults, so any
    // dump in progress is dropped; settings must be made afterwards.
    if (test_req && !soft_req) begin
      st_d.mode = IMS_TEST;
      st_d.cfg = `IMS_CFG_RESET;
      st_d.frame_period = `IMS_FP_RESET;
      st_d.pix_sel = `IMS_PIX_FIRST;
      st_d.crc = `IMS_CRC_SEED;
      st_d.dump_done = 1'b0;
      st_d.out_lo = `IMS_OUT_INVALID;
      st_d.exp_clear = 1'b1;
    end

    // Soft reset wins over every other write effect
    if (soft_req) begin
      st_d = reset_state();
      st_d.exp_clear = 1'b1;
    end

    // Illumination stays on when awake or while dumping
    st_d.led_on = st_d.cfg[`IMS_CFG_AWAKE] || !st_d.cfg[`IMS_CFG_LED_SHUTTER]
                  || st_d.mode == IMS_DUMP;
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= reset_state();
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs, each a field of the state register except exposure_q
  assign rd_data_q = st_q.rd_data;
  assign pix_sel_q = st_q.pix_sel;
  assign frame_end_q = st_q.frame_end;
  assign led_on_q = st_q.led_on;
  assign exposure_q = exposure; // Flip-flop inside the exposure loop

endmodule // ims_readout

// ### ims_readout_monitor.sv
// Port checks for the readout block: read timing, exposure steps, frame length.
// Assumes the frame period stays at reset value until 0x11 is written.
module ims_readout_monitor (
  input wire logic core_clk,
  input wire logic reset,
  input wire ims_pkg::ims_bus_req_t bus_req,
  input wire logic [7:0] rd_data_q,
  input wire logic [5:0] max_pixel,
  input wire logic [7:0] pix_sel_q,
  input wire logic frame_end_q,
  input wire logic led_on_q,
  input wire logic [15:0] exposure_q
);
  import ims_pkg::*;
  // ==========================================================
  // Helper logic
  logic cfg_wr;
  logic [15:0] up_step;
  logic [15:0] gap_q;
  logic gap_ok_q;
  logic dflt_q;
  assign cfg_wr = bus_req.wr && bus_req.addr == 8'h0a;
  assign up_step = (exposure_q[15:4] == 12'h000) ? 16'h0001 : {4'h0, exposure_q[15:4]};
  // Gap is trusted only for whole frames after any period change
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b0;
      dflt_q <= 1'b1;
    end else begin
      gap_q <= frame_end_q ? 16'h0001 : gap_q + 16'h0001;
      if ((cfg_wr && (bus_req.wdata[7] || bus_req.wdata[5])) || (bus_req.wr && bus_req.addr == 8'h11)) begin
        gap_ok_q <= 1'b0;
      end else if (frame_end_q) begin
        gap_ok_q <= 1'b1;
      end
      if (cfg_wr && (bus_req.wdata[7] || bus_req.wdata[5])) begin
        dflt_q <= 1'b1;
      end else if (bus_req.wr && bus_req.addr == 8'h11) begin
        dflt_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  rd_quiet_a: assert property (!$past(bus_req.rd) |-> rd_data_q == 8'h00)
    else $error("read data outside answer cycle");
  lo_bit6_a: assert property (bus_req.rd && bus_req.addr == 8'h0c |=> !rd_data_q[6])
    else $error("lower byte bit 6 set");
  exp_hi_read_a: assert property (bus_req.rd && bus_req.addr == 8'h0f |=> rd_data_q == 8'($past(exposure_q) >> 8))
    else $error("exposure upper byte wrong");
  exp_lo_pair_a: assert property (bus_req.rd && bus_req.addr == 8'h0f ##1 bus_req.rd && bus_req.addr == 8'h0e
    |=> rd_data_q == 8'($past(exposure_q, 2)))
    else $error("exposure lower byte not latched");
  exp_down_a: assert property (frame_end_q && max_pixel > 6'h39 && exposure_q >= 16'h0020
    |=> exposure_q == $past(exposure_q) - ($past(exposure_q) >> 4))
    else $error("exposure down step wrong");
  exp_up_a: assert property (frame_end_q && max_pixel < 6'h35 && dflt_q && exposure_q < 16'h2000
    |=> exposure_q == $past(exposure_q) + $past(up_step))
    else $error("exposure up step wrong");
  exp_hold_a: assert property (!frame_end_q && !cfg_wr && !$past(cfg_wr) |=> $stable(exposure_q))
    else $error("exposure moved between frames");
  exp_cap_a: assert property (dflt_q |-> exposure_q <= 16'h23e0)
    else $error("exposure above cap");
  frame_len_a: assert property (frame_end_q && gap_ok_q && dflt_q |-> gap_q == 16'h2ee0)
    else $error("frame length wrong");
  pix_walk_a: assert property ($changed(pix_sel_q) |-> pix_sel_q == 8'($past(pix_sel_q) + 8'h01) || pix_sel_q == 8'h00)
    else $error("pixel address jumped");
  led_awake_a: assert property (cfg_wr && bus_req.wdata[0] && !bus_req.wdata[7] && !bus_req.wdata[5] |=> led_on_q)
    else $error("illumination off while awake");
  cover property (frame_end_q);
  cover property (cfg_wr && bus_req.wdata[3]);
  cover property (bus_req.rd && bus_req.addr == 8'h0f ##1 bus_req.rd && bus_req.addr == 8'h0e);
endmodule // ims_readout_monitor

bind ims_readout ims_readout_monitor i_mon (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
  .rd_data_q(rd_data_q), .max_pixel(max_pixel), .pix_sel_q(pix_sel_q), .frame_end_q(frame_end_q),
  .led_on_q(led_on_q), .exposure_q(exposure_q));

// ### ims_pix_model.sv
// Behavioural pixel array answering the addressed pixel in the same cycle.
// Assumes the readout block holds the address for a whole cycle.
module ims_pix_model (
  input wire logic [7:0] pix_sel,
  input wire logic [5:0] seed,
  output logic [5:0] pix_sample
);
  // Scrambled pattern hits every level from dark to full bright
  assign pix_sample = 6'(pix_sel * 8'h07 + {2'b00, seed});
endmodule // ims_pix_model

// ### tb_top.sv
// Bench for the readout block: reads, self test, exposure loop, full dump.
// Assumes the design package is compiled first; model kept in integers.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ims_pkg::*;
  localparam logic [15:0] PASS_W = 16'h5a3c;
  localparam logic [15:0] FAIL_W = 16'hc3a5;
  // Reference signature of the pixel model's array walk, MSB first
  function automatic logic [15:0] ref_crc(input logic [5:0] sd);
    logic [15:0] c;
    logic [7:0] d;
    c = 16'hffff;
    for (int a = 0; a < 256; a++) begin
      d = 8'((a * 7 + int'(sd)) % 64);
      for (int i = 7; i >= 0; i--) begin
        c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
  // Golden signature is the one seed zero gives, so both result words get exercised
  localparam logic [15:0] GOLD_C = ref_crc(6'h00);
  logic core_clk;
  logic reset;
  ims_bus_req_t bus_req;
  logic [7:0] rd_data_q;
  logic [5:0] pix_sample;
  logic [5:0] max_pixel;
  logic [7:0] pix_sel_q;
  logic frame_end_q;
  logic led_on_q;
  logic [15:0] exposure_q;
  logic [5:0] pix_seed;
  logic [15:0] w;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int m_exp = 100;
  int q[$];

  ims_readout #(.TEST_PASS_WORD(PASS_W), .TEST_FAIL_WORD(FAIL_W), .TEST_GOLDEN_CRC(GOLD_C)) i_dut (
    .core_clk(core_clk), .reset(reset),
    .bus_req(bus_req), .rd_data_q(rd_data_q), .pix_sample(pix_sample), .max_pixel(max_pixel),
    .pix_sel_q(pix_sel_q), .frame_end_q(frame_end_q), .led_on_q(led_on_q), .exposure_q(exposure_q));
  ims_pix_model i_pix (.pix_sel(pix_sel_q), .seed(pix_seed), .pix_sample(pix_sample));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Cycle ceiling; the full sequence needs roughly 85400 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      bad_count++;
      close_out();
    end
  end
  // Exposure model; cap ignored since compared values stay small
  always @(posedge core_clk) begin
    if (reset || (bus_req.wr && bus_req.addr == 8'h0a && bus_req.wdata[5])) begin
      m_exp <= 100;
    end else if (frame_end_q) begin
      if (max_pixel > 6'h39) m_exp <= (m_exp - m_exp / 16 < 16) ? 16 : m_exp - m_exp / 16;
      else if (max_pixel < 6'h35) m_exp <= m_exp + ((m_exp < 16) ? 1 : m_exp / 16);
    end
  end
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{1'b0, 1'b1, a, d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  // Back-to-back reads, upper byte first so the pair stays coherent
  task automatic rd_pair(input logic [7:0] a1, input logic [7:0] a0, output logic [15:0] v);
    @(posedge core_clk);
    bus_req <= '{1'b1, 1'b0, a1, 8'h00};
    @(posedge core_clk);
    bus_req <= '{1'b1, 1'b0, a0, 8'h00};
    #1 v[15:8] = rd_data_q;
    @(posedge core_clk);
    bus_req <= '0;
    #1 v[7:0] = rd_data_q;
  endtask
  task automatic wait_frame();
    for (int i = 0; i < 13000; i++) begin
      @(posedge core_clk);
      #1;
      if (frame_end_q === 1'b1) break;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    bus_req = '0;
    max_pixel = 6'h37;
    pix_seed = 6'($urandom(53));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    wr_reg(8'h0e, 8'hff);
    rd_pair(8'h0f, 8'h0e, w);
    chk("exposure at reset", 16'h0064, w);
    rd_pair(8'h0b, 8'h20, w);
    chk("reserved and unmapped", 16'h0000, w);
    // Random seed first, then the seed whose signature is the golden one
    for (int t = 0; t < 2; t++) begin
      if (t == 1) pix_seed <= 6'h00;
      wr_reg(8'h0a, 8'h20);
      rd_pair(8'h0d, 8'h0c, w);
      chk("test busy", 16'h0080, {8'h00, w[7:0]});
      repeat (260) @(posedge core_clk);
      rd_pair(8'h0d, 8'h0c, w);
      chk("test word", (ref_crc(pix_seed) == GOLD_C) ? PASS_W : FAIL_W, w);
    end
    // One frame too bright, then one too dark
    for (int f = 0; f < 2; f++) begin
      @(posedge core_clk);
      max_pixel <= (f == 0) ? 6'($urandom_range(63, 58)) : 6'($urandom_range(52, 0));
      wait_frame();
      rd_pair(8'h0f, 8'h0e, w);
      chk("exposure", 16'(m_exp), w);
    end
    // Short frames so the whole array fits in the run
    wr_reg(8'h10, 8'h40);
    wr_reg(8'h11, 8'hff);
    wait_frame();
    wr_reg(8'h0a, 8'h09);
    rd_pair(8'h0d, 8'h0c, w);
    chk("dump start", 16'h0080, w);
    for (int a = 0; a < 256; a++) q.push_back((a * 7 + pix_seed) % 64);
    for (int a = 0; a < 256; a++) begin
      @(posedge core_clk);
      max_pixel <= 6'($urandom_range(63, 0));
      wait_frame();
      rd_pair(8'h0d, 8'h0c, w);
      chk("dump pixel", {8'(a), 8'(q[a])}, w);
    end
    wait_frame();
    rd_pair(8'h0d, 8'h0c, w);
    chk("dump end", {8'hff, 8'(q[255])}, w);
    wr_reg(8'h0a, 8'h01);
    // Dump bit reads back cleared and the last published address stays
    rd_pair(8'h0a, 8'h0d, w);
    chk("dump stopped", 16'h01ff, w);
    close_out();
  end
endmodule // tb_top
